//--- dv/mwtc_mem_model.sv
// Passive model of the external memory that times every write at its pins.
`timescale 1ns/10ps
`default_nettype none
module mwtc_mem_model (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_in,
    // Memory pins.
    input wire logic cs_n_in,
    input wire logic adv_n_in,
    input wire logic we_n_in,
    input wire logic [15:0] ad_in,
    input wire logic ad_oe_in,
    // Phases and values seen in the last write.
    output logic [8:0] set_out,
    output logic [8:0] hld_out,
    output logic [8:0] dat_out,
    output logic [8:0] gap_out,
    output logic [15:0] wdata_out,
    output logic [15:0] sad_out
);
    // ----------------------------------------------------------------
    // Phase counters.
    // ----------------------------------------------------------------
    logic cs_q;
    logic [8:0] idle;
    // Counts restart when chip select falls, so a stretched phase cannot hide in an older total.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cs_q <= 1'b1;
            idle <= 9'h000;
        end else begin
            cs_q <= cs_n_in;
            if (cs_n_in) begin
                idle <= idle + 9'h001;
            end else if (cs_q) begin
                gap_out <= idle;
                idle <= 9'h000;
                set_out <= {8'h00, !adv_n_in};
                hld_out <= {8'h00, adv_n_in && we_n_in};
                dat_out <= {8'h00, !we_n_in};
            end else begin
                set_out <= set_out + {8'h00, !adv_n_in};
                hld_out <= hld_out + {8'h00, adv_n_in && we_n_in};
                dat_out <= dat_out + {8'h00, !we_n_in};
            end
            // An undriven bus is seen inverted, so a missing enable cannot pass for data.
            if (!we_n_in) begin
                wdata_out <= ad_oe_in ? ad_in : ~ad_in;
            end
            if (!adv_n_in) begin
                sad_out <= ad_oe_in ? ad_in : 16'h0000;
            end
        end
    end
endmodule : mwtc_mem_model
`default_nettype wire

//--- dv/mwtc_tb_top.sv
// Self-checking testbench of the write timing block against the memory model.
`timescale 1ns/10ps
`default_nettype none
module mwtc_tb_top;
    import mwtc_pkg::*;
    // ----------------------------------------------------------------
    // Signals and cases.
    // ----------------------------------------------------------------
    typedef struct packed {logic [15:0] c; logic [31:0] w; logic sy; logic [8:0] s, h, d, t; logic [1:0] m;} mwtc_case_t;
    logic sys_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic wr_req = 1'b0, wr_sync = 1'b0, wr_ready, cs_n, adv_n, we_n, ad_oe;
    logic [25:0] wr_addr = 26'h000_0000, maddr;
    logic [15:0] wr_data = 16'h0000, ad, wdat, sad;
    logic [1:0] mmode;
    logic [8:0] s_m, h_m, d_m, g_m;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    mwtc_case_t cs [8];
    mwtc_top i_mwtc_top (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .wr_req_in(wr_req), .wr_sync_in(wr_sync), .wr_addr_in(wr_addr),
        .wr_data_in(wr_data), .wr_ready_out(wr_ready), .mem_cs_n_out(cs_n), .mem_adv_n_out(adv_n),
        .mem_we_n_out(we_n), .mem_addr_out(maddr), .mem_ad_out(ad), .mem_ad_oe_out(ad_oe), .mem_mode_out(mmode));
    mwtc_mem_model i_mwtc_mem_model (.clk_in(sys_clk_in), .rst_in(sys_rst_in), .cs_n_in(cs_n), .adv_n_in(adv_n),
        .we_n_in(we_n), .ad_in(ad), .ad_oe_in(ad_oe), .set_out(s_m), .hld_out(h_m), .dat_out(d_m), .gap_out(g_m),
        .wdata_out(wdat), .sad_out(sad));
    // ----------------------------------------------------------------
    // Tasks.
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    // Whole-word transfers only; read data is taken at the rising edge that samples pready high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_in);
        penable <= 1'b1;
        do @(posedge sys_clk_in); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // The request stays up until an edge sees it with the ready level high.
    task automatic mwr(input logic [15:0] d);
        @(posedge sys_clk_in);
        wr_req <= 1'b1;
        wr_data <= d;
        do @(posedge sys_clk_in); while (wr_ready !== 1'b1);
        wr_req <= 1'b0;
    endtask : mwr
    // ----------------------------------------------------------------
    // Clock, timeout and main sequence.
    // ----------------------------------------------------------------
    initial forever #25 sys_clk_in = ~sys_clk_in;
    // A hang counts as a mismatch; the whole run needs well under this many cycles.
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            error_cnt++;
            stop_test();
        end
    end
    // Case 0 has extended mode off, so the read timing and mode A must govern the write.
    initial begin
        cs = '{'{16'h0009, 32'h3FF1_0501, 1'b0, 9'd3, 9'd0, 9'd4, 9'd1, 2'h0},
               '{16'h4009, 32'h0FF1_0501, 1'b0, 9'd2, 9'd0, 9'd6, 9'd2, 2'h0},
               '{16'h4009, 32'h1FF2_0100, 1'b0, 9'd1, 9'd0, 9'd2, 9'd3, 2'h1},
               '{16'h4009, 32'h2FF0_0F0F, 1'b0, 9'd16, 9'd0, 9'd16, 9'd1, 2'h2},
               '{16'h4009, 32'h3FF3_02F1, 1'b0, 9'd2, 9'd16, 9'd3, 9'd4, 2'h3},
               '{16'h400B, 32'h0FF0_0231, 1'b0, 9'd2, 9'd4, 9'd3, 9'd1, 2'h0},
               '{16'h4009, 32'h0FF0_0505, 1'b1, 9'd1, 9'd0, 9'd1, 9'd1, 2'h0},
               '{16'h4005, 32'h0FF0_0303, 1'b0, 9'd1, 9'd0, 9'd4, 9'd1, 2'h0}};
        repeat (10) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        apb(1'b0, REG_WRT_OFS, 32'h0000_0000);
        check(rd, 32'h0FFF_FFFF);
        apb(1'b0, 12'h200, 32'h0000_0000);
        check({31'h0000_0000, err}, 32'h0000_0001);
        check(rd, 32'h0000_0000);
        apb(1'b1, REG_WRT_OFS, 32'h3FF3_0201);
        apb(1'b0, REG_WRT_OFS, 32'h0000_0000);
        check(rd, 32'h3FF3_0201);
        apb(1'b1, REG_RDT_OFS, 32'h0000_0302);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, REG_CTRL_OFS, {16'h0000, cs[i].c});
            apb(1'b1, REG_WRT_OFS, cs[i].w);
            wr_sync <= cs[i].sy;
            wr_addr <= 26'h2A5_5A00 + 26'(i);
            mwr(16'hC3A0 + 16'(i));
            mwr(16'h3C50 + 16'(i));
            do @(posedge sys_clk_in); while (wr_ready !== 1'b1);
            check(s_m, cs[i].s);
            check(h_m, cs[i].h);
            check(d_m, cs[i].d);
            check(g_m >= cs[i].t + 9'd1 && g_m <= cs[i].t + 9'd3, 1'b1);
            check(mmode, cs[i].m);
            check(wdat, 16'h3C50 + 16'(i));
            check(maddr, 26'h2A5_5A00 + 26'(i));
            check(sad, cs[i].c[1] ? 16'h5A00 + 16'(i) : 16'h0000);
        end
        stop_test();
    end
endmodule : mwtc_tb_top
`default_nettype wire

//--- verilog/mwtc_pkg.sv
// Constants and types of the external memory write timing block.
package mwtc_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses on the APB).
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] REG_CTRL_OFS = 12'h000;
    localparam logic [11:0] REG_RDT_OFS = 12'h004;
    localparam logic [11:0] REG_WRT_OFS = 12'h104;
    localparam logic [11:0] REG_STAT_OFS = 12'h108;

    // ------------------------------------------------------------------
    // Reset values and writable masks.
    // ------------------------------------------------------------------
    localparam logic [31:0] WRT_RESET = 32'h0FFF_FFFF;
    localparam logic [31:0] RDT_RESET = 32'h0FFF_FFFF;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0008;
    localparam logic [31:0] WRT_MASK = 32'h300F_FFFF;
    localparam logic [31:0] RDT_MASK = 32'h3FFF_FFFF;
    localparam logic [31:0] CTRL_MASK = 32'h0000_400F;

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int F_SET_LSB = 0;
    localparam int F_HLD_LSB = 4;
    localparam int F_DSET_LSB = 8;
    localparam int F_LAT_LSB = 16;
    localparam int F_MODE_LSB = 28;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MUX_BIT = 1;
    localparam int CTRL_TYPE_LSB = 2;
    localparam int CTRL_EXT_BIT = 14;

    // ------------------------------------------------------------------
    // Encodings.
    // ------------------------------------------------------------------
    localparam logic [1:0] TYPE_SRAM = 2'h0;
    localparam logic [1:0] TYPE_NOR = 2'h2;
    localparam logic [1:0] MODE_A = 2'h0;
    localparam logic [1:0] MODE_D = 2'h3;

    typedef enum logic [2:0] {MWTC_IDLE, MWTC_SETUP, MWTC_HOLD, MWTC_DATA, MWTC_TURN} mwtc_phase_t;

endpackage : mwtc_pkg

//--- verilog/mwtc_seq_if.sv
// Interface between the register side and the write phase sequencer.
`timescale 1ns/10ps
`default_nettype none
interface mwtc_seq_if;
    import mwtc_pkg::*;
    logic start;
    logic [4:0] setup_cyc;
    logic [4:0] hold_cyc;
    logic [8:0] data_cyc;
    logic [4:0] turn_cyc;
    mwtc_phase_t phase;
    logic busy;
    modport ctl (output start, setup_cyc, hold_cyc, data_cyc, turn_cyc, input phase, busy);
    modport seq (input start, setup_cyc, hold_cyc, data_cyc, turn_cyc, output phase, busy);
endinterface : mwtc_seq_if
`default_nettype wire

//--- verilog/mwtc_top.sv
// Write timing register block and asynchronous write pin driver.
//
// Behaviour
// - Write timing settings govern writes only while extended mode is on, else read timing does.
// - The mode field picks write waveform A, B, C or D by codes 00 to 11.
// - Each write ends with a turnaround gap of field plus one cycles.
// - The write data phase lasts field plus one cycles; code zero is reserved.
// - The data phase length is applied to asynchronous writes only.
// - An address hold of field plus one cycles is inserted only in mode D or multiplexed mode.
// - The address setup phase lasts field plus one cycles.
// - The setup length is applied only to asynchronous SRAM, ROM or NOR accesses.
// - Reset loads the write timing register with 0x0FFFFFFF.
// - Address and data share the bus when multiplexing is enabled.
`timescale 1ns/10ps
`default_nettype none
module mwtc_top
    import mwtc_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // APB slave.
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Write request from the system side.
    input wire logic wr_req_in,
    input wire logic wr_sync_in,
    input wire logic [25:0] wr_addr_in,
    input wire logic [15:0] wr_data_in,
    output logic wr_ready_out,
    // External memory pins.
    output logic mem_cs_n_out,
    output logic mem_adv_n_out,
    output logic mem_we_n_out,
    output logic [25:0] mem_addr_out,
    output logic [15:0] mem_ad_out,
    output logic mem_ad_oe_out,
    output logic [1:0] mem_mode_out
);

    // ------------------------------------------------------------------
    // Registers.
    // ------------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [31:0] rdt_reg;
    logic [31:0] wrt_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic ready_reg;
    logic [25:0] addr_reg;
    logic [15:0] data_reg;
    logic [1:0] mode_reg;
    logic mux_reg;
    logic cs_n_reg;
    logic adv_n_reg;
    logic we_n_reg;
    logic [15:0] ad_reg;
    logic oe_reg;

    mwtc_seq_if sq ();

    mwtc_write_seq u_seq (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .sq(sq.seq)
    );

    // ------------------------------------------------------------------
    // APB decode.
    // ------------------------------------------------------------------
    // Access phase; the slave adds one wait state so read data comes from a flop.
    wire access_w = psel_in && penable_in;
    wire first_w = access_w && !pready_reg;
    wire done_w = access_w && pready_reg;
    wire hit_ctrl_w = (paddr_in == REG_CTRL_OFS);
    wire hit_rdt_w = (paddr_in == REG_RDT_OFS);
    wire hit_wrt_w = (paddr_in == REG_WRT_OFS);
    wire hit_stat_w = (paddr_in == REG_STAT_OFS);
    wire hit_w = hit_ctrl_w || hit_rdt_w || hit_wrt_w || hit_stat_w;
    wire wr_en_w = done_w && pwrite_in;

    // Writes merge the fixed reserved bits back in, so they always read as reset.
    wire [31:0] wrt_wdata_w = (pwdata_in & WRT_MASK) | (WRT_RESET & ~WRT_MASK);
    wire [31:0] rdt_wdata_w = (pwdata_in & RDT_MASK) | (RDT_RESET & ~RDT_MASK);
    wire [31:0] ctrl_wdata_w = pwdata_in & CTRL_MASK;

    // ------------------------------------------------------------------
    // Effective timing selection.
    // ------------------------------------------------------------------
    wire ext_w = ctrl_reg[CTRL_EXT_BIT];
    wire mux_w = ctrl_reg[CTRL_MUX_BIT];
    wire en_w = ctrl_reg[CTRL_EN_BIT];
    wire [1:0] type_w = ctrl_reg[CTRL_TYPE_LSB +: 2];
    // Without extended mode the read timing governs writes too.
    wire [31:0] tim_w = ext_w ? wrt_reg : rdt_reg;
    wire [1:0] mode_w = ext_w ? wrt_reg[F_MODE_LSB +: 2] : MODE_A;
    // PSRAM and synchronous writes get a single setup cycle.
    wire setup_used_w = !wr_sync_in && (type_w == TYPE_SRAM || type_w == TYPE_NOR);
    wire hold_used_w = (mode_w == MODE_D) || mux_w;
    wire [4:0] setup_cyc_w = setup_used_w ? {1'b0, tim_w[F_SET_LSB +: 4]} + 5'h01 : 5'h01;
    wire [4:0] hold_cyc_w = hold_used_w ? {1'b0, tim_w[F_HLD_LSB +: 4]} + 5'h01 : 5'h00;
    // A reserved data code of zero still gives one cycle rather than none.
    wire [8:0] data_cyc_w = wr_sync_in ? 9'h001 : {1'b0, tim_w[F_DSET_LSB +: 8]} + 9'h001;
    wire [4:0] turn_cyc_w = {1'b0, tim_w[F_LAT_LSB +: 4]} + 5'h01;
    wire take_w = wr_req_in && ready_reg;

    assign sq.start = take_w;
    assign sq.setup_cyc = setup_cyc_w;
    assign sq.hold_cyc = hold_cyc_w;
    assign sq.data_cyc = data_cyc_w;
    assign sq.turn_cyc = turn_cyc_w;

    // ------------------------------------------------------------------
    // Read mux and status.
    // ------------------------------------------------------------------
    wire [31:0] stat_w = {28'h0000000, ext_w, mode_reg, sq.busy};
    wire [31:0] rd_mux_w = hit_ctrl_w ? ctrl_reg :
                           hit_rdt_w ? rdt_reg :
                           hit_wrt_w ? wrt_reg :
                           hit_stat_w ? stat_w : 32'h0000_0000;

    // ------------------------------------------------------------------
    // Pin decode from the sequencer phase.
    // ------------------------------------------------------------------
    wire ph_setup_w = (sq.phase == MWTC_SETUP);
    wire ph_hold_w = (sq.phase == MWTC_HOLD);
    wire ph_data_w = (sq.phase == MWTC_DATA);
    wire cs_n_w = !(ph_setup_w || ph_hold_w || ph_data_w);
    // The shared bus carries the address before data only when multiplexed.
    wire oe_w = ph_data_w || (mux_reg && (ph_setup_w || ph_hold_w));
    wire [15:0] ad_w = ph_data_w ? data_reg : (mux_reg ? addr_reg[15:0] : 16'h0000);

    // ------------------------------------------------------------------
    // APB registers.
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= first_w;
            pslverr_reg <= first_w && !hit_w;
            prdata_reg <= (first_w && !pwrite_in) ? rd_mux_w : 32'h0000_0000;
        end
    end

    // Configuration registers; writes take effect on the completing edge only.
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctrl_reg <= CTRL_RESET;
            rdt_reg <= RDT_RESET;
            wrt_reg <= WRT_RESET;
        end else begin
            if (wr_en_w && hit_ctrl_w) begin
                ctrl_reg <= ctrl_wdata_w;
            end
            if (wr_en_w && hit_rdt_w) begin
                rdt_reg <= rdt_wdata_w;
            end
            if (wr_en_w && hit_wrt_w) begin
                wrt_reg <= wrt_wdata_w;
            end
        end
    end

    // ------------------------------------------------------------------
    // Request capture.
    // ------------------------------------------------------------------
    // Ready drops for the edge after a take so a request is never taken twice.
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ready_reg <= 1'b0;
            addr_reg <= 26'h0000000;
            data_reg <= 16'h0000;
            mode_reg <= MODE_A;
            mux_reg <= 1'b0;
        end else begin
            ready_reg <= en_w && !sq.busy && !take_w;
            if (take_w) begin
                addr_reg <= wr_addr_in;
                data_reg <= wr_data_in;
                mode_reg <= mode_w;
                mux_reg <= mux_w;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin registers.
    // ------------------------------------------------------------------
    // Pins trail the phase by one cycle so every output leaves a flop.
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cs_n_reg <= 1'b1;
            adv_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            ad_reg <= 16'h0000;
            oe_reg <= 1'b0;
        end else begin
            cs_n_reg <= cs_n_w;
            adv_n_reg <= !ph_setup_w;
            we_n_reg <= !ph_data_w;
            ad_reg <= ad_w;
            oe_reg <= oe_w;
        end
    end

    assign prdata_out = prdata_reg;
    assign pready_out = pready_reg;
    assign pslverr_out = pslverr_reg;
    assign wr_ready_out = ready_reg;
    assign mem_cs_n_out = cs_n_reg;
    assign mem_adv_n_out = adv_n_reg;
    assign mem_we_n_out = we_n_reg;
    assign mem_addr_out = addr_reg;
    assign mem_ad_out = ad_reg;
    assign mem_ad_oe_out = oe_reg;
    assign mem_mode_out = mode_reg;

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    sequence s_take_async;
        take_w && !wr_sync_in;
    endsequence

    sequence s_setup_on_pins;
        !mem_adv_n_out && mux_reg;
    endsequence

    a_ext_fallback: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (take_w && !ext_w) |-> turn_cyc_w == {1'b0, rdt_reg[F_LAT_LSB +: 4]} + 5'h01 && mode_w == MODE_A)
        else $error("Write timing used while extended mode is off.");
    a_mode_latch: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (take_w && ext_w) |=> mem_mode_out == $past(wrt_reg[F_MODE_LSB +: 2]))
        else $error("Write mode not taken from the mode field.");
    a_turn_from_field: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (take_w && ext_w) |-> sq.turn_cyc == {1'b0, wrt_reg[F_LAT_LSB +: 4]} + 5'h01)
        else $error("Turnaround length not field plus one.");
    a_data_async: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (s_take_async and ext_w) |-> sq.data_cyc == {1'b0, wrt_reg[F_DSET_LSB +: 8]} + 9'h001)
        else $error("Data phase length not field plus one.");
    a_data_sync: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (take_w && wr_sync_in) |-> sq.data_cyc == 9'h001 && sq.setup_cyc == 5'h01)
        else $error("Asynchronous lengths applied to a synchronous write.");
    a_hold_gate: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (take_w && mode_w != MODE_D && !mux_w) |-> sq.hold_cyc == 5'h00)
        else $error("Address hold used outside mode D and multiplexing.");
    a_setup_type: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (s_take_async and ext_w and (type_w == TYPE_NOR)) |-> sq.setup_cyc == {1'b0, wrt_reg[3:0]} + 5'h01)
        else $error("Setup length not applied to an asynchronous NOR write.");
    a_wrt_reset: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        $past(sys_rst_in) |-> wrt_reg == WRT_RESET)
        else $error("Write timing register not at reset value.");
    a_mux_address: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        s_setup_on_pins |-> mem_ad_oe_out && mem_ad_out == mem_addr_out[15:0])
        else $error("Multiplexed bus does not carry the address.");

endmodule : mwtc_top
`default_nettype wire

//--- verilog/mwtc_write_seq.sv
// Write phase sequencer: setup, hold, data and turnaround counting.
`timescale 1ns/10ps
`default_nettype none
module mwtc_write_seq
    import mwtc_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // Link to the register side.
    mwtc_seq_if.seq sq
);

    // ------------------------------------------------------------------
    // State and latched lengths.
    // ------------------------------------------------------------------
    mwtc_phase_t phase_reg, phase_next;
    logic [8:0] cnt_reg, cnt_next;
    logic [4:0] hlen_reg;
    logic [8:0] dlen_reg;
    logic [4:0] tlen_reg;
    logic [8:0] plen_reg;
    wire last_w = (cnt_reg == 9'h000);

    assign sq.phase = phase_reg;
    assign sq.busy = (phase_reg != MWTC_IDLE);

    // Each phase loads its length minus one and leaves when the count hits zero.
    always_comb begin
        phase_next = phase_reg;
        cnt_next = (cnt_reg == 9'h000) ? 9'h000 : cnt_reg - 9'h001;
        unique case (phase_reg)
            MWTC_IDLE: begin
                if (sq.start) begin
                    phase_next = MWTC_SETUP;
                    cnt_next = {4'h0, sq.setup_cyc - 5'h01};
                end
            end
            MWTC_SETUP: begin
                if (last_w && hlen_reg != 5'h00) begin
                    phase_next = MWTC_HOLD;
                    cnt_next = {4'h0, hlen_reg - 5'h01};
                end else if (last_w) begin
                    phase_next = MWTC_DATA;
                    cnt_next = dlen_reg - 9'h001;
                end
            end
            MWTC_HOLD: begin
                if (last_w) begin
                    phase_next = MWTC_DATA;
                    cnt_next = dlen_reg - 9'h001;
                end
            end
            MWTC_DATA: begin
                if (last_w) begin
                    phase_next = MWTC_TURN;
                    cnt_next = {4'h0, tlen_reg - 5'h01};
                end
            end
            MWTC_TURN: begin
                if (last_w) begin
                    phase_next = MWTC_IDLE;
                end
            end
        endcase
    end

    // Lengths are frozen at start so a register write mid-access cannot tear it.
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            phase_reg <= MWTC_IDLE;
            cnt_reg <= 9'h000;
            hlen_reg <= 5'h00;
            dlen_reg <= 9'h001;
            tlen_reg <= 5'h01;
        end else begin
            phase_reg <= phase_next;
            cnt_reg <= cnt_next;
            if (sq.start && phase_reg == MWTC_IDLE) begin
                hlen_reg <= sq.hold_cyc;
                dlen_reg <= sq.data_cyc;
                tlen_reg <= sq.turn_cyc;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks on phase lengths.
    // ------------------------------------------------------------------
    // Helper count of cycles spent in the current phase.
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            plen_reg <= 9'h001;
        end else begin
            plen_reg <= (phase_next != phase_reg) ? 9'h001 : plen_reg + 9'h001;
        end
    end

    sequence s_leave(mwtc_phase_t p);
        phase_reg == p ##1 phase_reg != p;
    endsequence

    a_turn_length: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        s_leave(MWTC_TURN) |-> $past(plen_reg) == {4'h0, tlen_reg})
        else $error("Turnaround phase length wrong.");
    a_data_length: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        s_leave(MWTC_DATA) |-> $past(plen_reg) == dlen_reg)
        else $error("Data phase length wrong.");
    a_hold_skip: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (phase_reg == MWTC_SETUP && hlen_reg == 5'h00) |-> phase_next != MWTC_HOLD)
        else $error("Hold phase entered although unused.");
    a_setup_enter: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (phase_reg == MWTC_IDLE && sq.start) |=> phase_reg == MWTC_SETUP && cnt_reg == {4'h0, $past(sq.setup_cyc) - 5'h01})
        else $error("Setup phase not loaded from its length.");

endmodule : mwtc_write_seq
`default_nettype wire
